/* core/timer_ctl_map.svh */
// Register offsets, field positions, reset values and counts of the timer control block
`ifndef TIMER_CTL_MAP_SVH
`define TIMER_CTL_MAP_SVH

// ----------------------------------------
// Offsets (byte addresses, one 16-bit word each)
// ----------------------------------------
`define CCR_BASE 8'h00
`define CNT_BASE 8'h10
`define GRA_BASE 8'h20
`define GRB_BASE 8'h30
`define BRA_BASE 8'h40
`define BRB_BASE 8'h44

// ----------------------------------------
// Counter control fields
// ----------------------------------------
`define CCR_RSV_BIT 7
`define CCR_CLR_HI 6
`define CCR_CLR_LO 5
`define CCR_EDGE_HI 4
`define CCR_EDGE_LO 3
`define CCR_CLK_HI 2
`define CCR_CLK_LO 0

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CCR_RST 8'h80
`define BUF_RST 16'hffff
`define GR_RST 16'hffff
`define CNT_RST 16'h0000
`define CNT_MAX 16'hffff
`define NUM_CH 5
`define NUM_BUF 4
`define PRESC_W 3

`endif

/* core/timer_ctl_pkg.sv */
// Types shared by the timer control block
package timer_ctl_pkg;

  // ----------------------------------------
  // Register bus request
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
    logic wr;
    logic rd;
  } bus_req_t;

  // ----------------------------------------
  // Per-channel signals from neighbouring logic
  // ----------------------------------------
  typedef struct packed {
    logic cap_mode_a;
    logic cap_mode_b;
    logic cap_evt_a;
    logic cap_evt_b;
    logic sync_enroll;
  } chan_in_t;

  // ----------------------------------------
  // Per-channel flag set pulses
  // ----------------------------------------
  typedef struct packed {
    logic ovf;
    logic evt_a;
    logic evt_b;
  } flag_set_t;

endpackage

/* core/timer_ctl.sv */
// Clock select, clear select, counters and buffer registers of the five-channel timer
//
// Notes on behaviour
// - Four 16-bit buffers, channels 3 and 4.
// - Four separate buffer enable bits.
// - Compare match copies buffer into general reg.
// - Capture mode makes buffer a capture buffer.
// - Buffers all ones on reset, standby.
// - Buffers read/written by word or byte.
// - Five 8-bit control regs, reset 0x80.
// - Control bit 7 reads one, ignores writes.
// - Clear select: none, A, B, sync.
// - Clear uses match or capture by mode.
// - Sync clear follows enrolled channels.
// - Edge select: rising, falling, both.
// - Clock select: divided clock or external A-D.
// - Internal falling edges; external by edge select.
// - Phase mode ignores channel 2 edge select.
// - Phase mode ignores channel 2 clock select.
// - Compare mode matches counter, raises event.
// - Capture latches counter, raises event.
// - Counter clear loads zero.
`timescale 1ns/1ps
`include "timer_ctl_map.svh"

module timer_ctl
  import timer_ctl_pkg::*;
(
  // Clock, reset, enable, standby
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_standby,
  // Register bus
  input wire bus_req_t i_bus,
  output logic [15:0] o_bus_rdata,
  // External clock pins
  input wire logic i_ext_clock_in_a,
  input wire logic i_ext_clock_in_b,
  input wire logic i_ext_clock_in_c,
  input wire logic i_ext_clock_in_d,
  // Neighbouring timer logic
  input wire chan_in_t [4:0] i_chan,
  input wire logic [3:0] i_buffer_enable,
  input wire logic i_phase_count_enable,
  input wire logic i_phase_step,
  input wire logic i_phase_down,
  // Counter values and flag set pulses
  output logic [4:0][15:0] o_counter,
  output flag_set_t [4:0] o_flag_set
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input logic [2:0] k);
    return a == 8'(base + {4'h0, k, 1'b0});
  endfunction
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [15:0] d, input logic [1:0] be);
    return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction
  function automatic logic presc_tick(input logic [2:0] p, input logic [1:0] div);
    logic t;
    case (div)
      2'd0: t = 1'b1;
      2'd1: t = p[0];
      2'd2: t = &p[1:0];
      default: t = &p[2:0];
    endcase
    return t;
  endfunction

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [4:0][7:0] ccr_q;
  logic [4:0][15:0] cnt_q, gra_q, grb_q;
  logic [3:0][15:0] buf_q;
  logic [4:0] eq_a_q, eq_b_q;
  logic [`PRESC_W-1:0] presc_q;
  logic [3:0] sync1_q, sync2_q, sync3_q, ext_lvl_q;
  logic [15:0] rdata_q;
  flag_set_t [4:0] flag_q;

  // ----------------------------------------
  // Combinational decode
  // ----------------------------------------
  logic [3:0] ext_in, ext_rise, ext_fall;
  logic [4:0] tick, down, eq_a, eq_b, ev_a, ev_b, own_clr, do_clr, ovf;
  logic sync_src;
  logic [4:0] wr_ccr, wr_cnt, wr_gra, wr_grb;
  logic [3:0] wr_buf;

  assign ext_in = {i_ext_clock_in_d, i_ext_clock_in_c, i_ext_clock_in_b, i_ext_clock_in_a};

  always_comb begin
    for (int e = 0; e < 4; e++) begin
      ext_rise[e] = (sync2_q[e] == sync3_q[e]) && sync3_q[e] && !ext_lvl_q[e];
      ext_fall[e] = (sync2_q[e] == sync3_q[e]) && !sync3_q[e] && ext_lvl_q[e];
    end
  end

  always_comb begin
    for (int c = 0; c < `NUM_CH; c++) begin
      logic [1:0] sel, edg, clr;
      sel = ccr_q[c][1:0];
      edg = ccr_q[c][`CCR_EDGE_HI:`CCR_EDGE_LO];
      clr = ccr_q[c][`CCR_CLR_HI:`CCR_CLR_LO];
      down[c] = 1'b0;
      if (c == 2 && i_phase_count_enable) begin
        tick[c] = i_phase_step;
        down[c] = i_phase_down;
      end else if (!ccr_q[c][`CCR_CLK_HI]) begin
        tick[c] = presc_tick(presc_q, sel);
      end else begin
        tick[c] = edg[1] ? (ext_rise[sel] | ext_fall[sel]) : (edg[0] ? ext_fall[sel] : ext_rise[sel]);
      end
      eq_a[c] = cnt_q[c] == gra_q[c];
      eq_b[c] = cnt_q[c] == grb_q[c];
      ev_a[c] = i_chan[c].cap_mode_a ? i_chan[c].cap_evt_a : (eq_a[c] && !eq_a_q[c]);
      ev_b[c] = i_chan[c].cap_mode_b ? i_chan[c].cap_evt_b : (eq_b[c] && !eq_b_q[c]);
      own_clr[c] = (clr == 2'b01 && ev_a[c]) || (clr == 2'b10 && ev_b[c]);
      ovf[c] = tick[c] && (down[c] ? cnt_q[c] == `CNT_RST : cnt_q[c] == `CNT_MAX);
    end
  end

  always_comb begin
    sync_src = 1'b0;
    for (int c = 0; c < `NUM_CH; c++) begin
      sync_src = sync_src | (i_chan[c].sync_enroll && own_clr[c]);
    end
    for (int c = 0; c < `NUM_CH; c++) begin
      do_clr[c] = own_clr[c] || (ccr_q[c][`CCR_CLR_HI:`CCR_CLR_LO] == 2'b11 && i_chan[c].sync_enroll && sync_src);
    end
  end

  // Write decode
  always_comb begin
    for (int c = 0; c < `NUM_CH; c++) begin
      wr_ccr[c] = i_bus.wr && i_bus.be[0] && hit(i_bus.addr, `CCR_BASE, 3'(c));
      wr_cnt[c] = i_bus.wr && hit(i_bus.addr, `CNT_BASE, 3'(c));
      wr_gra[c] = i_bus.wr && hit(i_bus.addr, `GRA_BASE, 3'(c));
      wr_grb[c] = i_bus.wr && hit(i_bus.addr, `GRB_BASE, 3'(c));
    end
    for (int k = 0; k < 2; k++) begin
      wr_buf[2*k] = i_bus.wr && hit(i_bus.addr, `BRA_BASE, 3'(k));
      wr_buf[2*k+1] = i_bus.wr && hit(i_bus.addr, `BRB_BASE, 3'(k));
    end
  end

  // ----------------------------------------
  // Prescaler and pin synchronisers
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= '0;
    end else if (i_ce) begin
      presc_q <= presc_q + 3'd1;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      sync3_q <= 4'h0;
      ext_lvl_q <= 4'h0;
    end else if (i_ce) begin
      sync1_q <= ext_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int e = 0; e < 4; e++) begin
        if (sync2_q[e] == sync3_q[e]) begin
          ext_lvl_q[e] <= sync3_q[e];
        end
      end
    end
  end

  // ----------------------------------------
  // Counter control registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ccr_q <= {`NUM_CH{`CCR_RST}};
    end else if (i_standby) begin
      ccr_q <= {`NUM_CH{`CCR_RST}};
    end else if (i_ce) begin
      for (int c = 0; c < `NUM_CH; c++) begin
        if (wr_ccr[c]) begin
          ccr_q[c] <= {1'b1, i_bus.wdata[6:0]};
        end
      end
    end
  end

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      eq_a_q <= 5'h00;
      eq_b_q <= 5'h00;
    end else if (i_standby) begin
      cnt_q <= '0;
      eq_a_q <= 5'h00;
      eq_b_q <= 5'h00;
    end else if (i_ce) begin
      eq_a_q <= eq_a;
      eq_b_q <= eq_b;
      for (int c = 0; c < `NUM_CH; c++) begin
        if (wr_cnt[c]) begin
          cnt_q[c] <= wr16(cnt_q[c], i_bus.wdata, i_bus.be);
        end else if (do_clr[c]) begin
          cnt_q[c] <= `CNT_RST;
        end else if (tick[c]) begin
          cnt_q[c] <= down[c] ? cnt_q[c] - 16'd1 : cnt_q[c] + 16'd1;
        end
      end
    end
  end

  // ----------------------------------------
  // General registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gra_q <= {`NUM_CH{`GR_RST}};
      grb_q <= {`NUM_CH{`GR_RST}};
    end else if (i_standby) begin
      gra_q <= {`NUM_CH{`GR_RST}};
      grb_q <= {`NUM_CH{`GR_RST}};
    end else if (i_ce) begin
      for (int c = 0; c < `NUM_CH; c++) begin
        if (i_chan[c].cap_mode_a && i_chan[c].cap_evt_a) begin
          gra_q[c] <= cnt_q[c];
        end else if (c >= 3 && i_buffer_enable[2*(c-3)] && ev_a[c]) begin
          gra_q[c] <= buf_q[2*(c-3)];
        end else if (wr_gra[c]) begin
          gra_q[c] <= wr16(gra_q[c], i_bus.wdata, i_bus.be);
        end
        if (i_chan[c].cap_mode_b && i_chan[c].cap_evt_b) begin
          grb_q[c] <= cnt_q[c];
        end else if (c >= 3 && i_buffer_enable[2*(c-3)+1] && ev_b[c]) begin
          grb_q[c] <= buf_q[2*(c-3)+1];
        end else if (wr_grb[c]) begin
          grb_q[c] <= wr16(grb_q[c], i_bus.wdata, i_bus.be);
        end
      end
    end
  end

  // ----------------------------------------
  // Buffer registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_q <= {`NUM_BUF{`BUF_RST}};
    end else if (i_standby) begin
      buf_q <= {`NUM_BUF{`BUF_RST}};
    end else if (i_ce) begin
      for (int k = 0; k < `NUM_BUF; k++) begin
        logic cap, cev;
        logic [15:0] gr;
        cap = k[0] ? i_chan[3+k/2].cap_mode_b : i_chan[3+k/2].cap_mode_a;
        cev = k[0] ? i_chan[3+k/2].cap_evt_b : i_chan[3+k/2].cap_evt_a;
        gr = k[0] ? grb_q[3+k/2] : gra_q[3+k/2];
        if (i_buffer_enable[k] && cap && cev) begin
          buf_q[k] <= gr;
        end else if (wr_buf[k]) begin
          buf_q[k] <= wr16(buf_q[k], i_bus.wdata, i_bus.be);
        end
      end
    end
  end

  // ----------------------------------------
  // Flag set pulses
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= '0;
    end else if (i_standby) begin
      flag_q <= '0;
    end else if (i_ce) begin
      for (int c = 0; c < `NUM_CH; c++) begin
        flag_q[c] <= '{ovf: ovf[c] && !do_clr[c] && !wr_cnt[c], evt_a: ev_a[c], evt_b: ev_b[c]};
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (i_ce && i_bus.rd) begin
      rdata_q <= 16'h0000;
      for (int c = 0; c < `NUM_CH; c++) begin
        if (hit(i_bus.addr, `CCR_BASE, 3'(c))) begin
          rdata_q <= {8'h00, ccr_q[c]};
        end else if (hit(i_bus.addr, `CNT_BASE, 3'(c))) begin
          rdata_q <= cnt_q[c];
        end else if (hit(i_bus.addr, `GRA_BASE, 3'(c))) begin
          rdata_q <= gra_q[c];
        end else if (hit(i_bus.addr, `GRB_BASE, 3'(c))) begin
          rdata_q <= grb_q[c];
        end
      end
      for (int k = 0; k < 2; k++) begin
        if (hit(i_bus.addr, `BRA_BASE, 3'(k))) begin
          rdata_q <= buf_q[2*k];
        end else if (hit(i_bus.addr, `BRB_BASE, 3'(k))) begin
          rdata_q <= buf_q[2*k+1];
        end
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_bus_rdata = rdata_q;
  assign o_counter = cnt_q;
  assign o_flag_set = flag_q;

endmodule

/* tb/cpu_bus_model.sv */
// CPU side register bus model for the timer control block
`timescale 1ns/1ps
module cpu_bus_model
  import timer_ctl_pkg::*;
(
  // Clock
  input wire logic i_core_clk,
  // Register bus
  output bus_req_t o_bus
);
  // ----------------------------------------
  // Bus requests
  // ----------------------------------------
  initial o_bus = '0;

  // One request, held over one edge, then lines released inverted
  task automatic access(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b, input logic w);
    @(posedge i_core_clk);
    #1;
    o_bus = '{addr: a, wdata: d, be: b, wr: w, rd: !w};
    @(posedge i_core_clk);
    #1;
    o_bus = '{addr: ~a, wdata: ~d, be: 2'b00, wr: 1'b0, rd: 1'b0};
  endtask
endmodule

/* tb/timer_ctl_monitor.sv */
// Concurrent checks on the timer control block ports
`timescale 1ns/1ps
module timer_ctl_monitor
  import timer_ctl_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Inputs watched
  input wire logic i_ce,
  input wire logic i_standby,
  input wire bus_req_t i_bus,
  input wire chan_in_t [4:0] i_chan,
  // Outputs watched
  input wire logic [15:0] o_bus_rdata,
  input wire logic [4:0][15:0] o_counter,
  input wire flag_set_t [4:0] o_flag_set
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence ctrl_rd_s;
    i_ce && i_bus.rd && i_bus.addr < 8'h0a && !i_bus.addr[0];
  endsequence
  sequence cap_a_s;
    i_ce && i_chan[4].cap_mode_a && i_chan[4].cap_evt_a;
  endsequence
  sequence cap_b_s;
    i_ce && i_chan[4].cap_mode_b && i_chan[4].cap_evt_b;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  reserved_bit_a: assert property (ctrl_rd_s |=> o_bus_rdata[7])
    else $error("control bit 7 read as zero");
  rdata_hold_a: assert property (!(i_ce && i_bus.rd) && !i_standby |=> $stable(o_bus_rdata))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (i_ce && i_bus.rd && i_bus.addr >= 8'h48 |=> o_bus_rdata == 16'h0)
    else $error("unmapped read not zero");
  standby_init_a: assert property (i_standby |=> o_counter == '0 && o_flag_set == '0)
    else $error("standby did not reinitialise");
  ce_freeze_a: assert property (!i_ce && !i_standby |=> $stable(o_counter))
    else $error("counter moved while disabled");
  count_step_a: assert property (!(i_ce && i_bus.wr) |=>
    o_counter[0] == $past(o_counter[0]) || o_counter[0] == $past(o_counter[0]) + 16'h1 || o_counter[0] == 16'h0)
    else $error("counter 0 jumped");
  cap_flag_a: assert property (cap_a_s |-> ##[1:2] o_flag_set[4].evt_a)
    else $error("capture A flag missing");
  cap_flag_b_a: assert property (cap_b_s |-> ##[1:2] o_flag_set[4].evt_b)
    else $error("capture B flag missing");
endmodule

bind timer_ctl timer_ctl_monitor timer_ctl_monitor_i (
  .i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b),
  .i_ce(i_ce),
  .i_standby(i_standby),
  .i_bus(i_bus),
  .i_chan(i_chan),
  .o_bus_rdata(o_bus_rdata),
  .o_counter(o_counter),
  .o_flag_set(o_flag_set)
);

/* tb/tb_timer_clock_clear_and_buffering.sv */
// Self-checking bench for the timer control block
`timescale 1ns/1ps
`include "timer_ctl_map.svh"
module tb_timer_clock_clear_and_buffering;
  import timer_ctl_pkg::*;
  typedef struct packed {logic [15:0] v; logic [15:0] m; logic [15:0] t;} note_t;
  logic clk, rst_b, ce, standby, penab, pstep, pdir, rd_seen;
  logic [3:0] pins, buf_en;
  logic [15:0] rdata, rnd;
  chan_in_t [4:0] chan;
  bus_req_t bus;
  logic [4:0][15:0] cnt;
  flag_set_t [4:0] flags;
  note_t q[$];
  note_t e;
  int fail_count, tests_run, cycles;

  // ----------------------------------------
  // Instances and clock
  // ----------------------------------------
  cpu_bus_model cpu_bus_model_i (.i_core_clk(clk), .o_bus(bus));
  timer_ctl timer_ctl_i (.i_core_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_standby(standby), .i_bus(bus),
    .o_bus_rdata(rdata), .i_ext_clock_in_a(pins[0]), .i_ext_clock_in_b(pins[1]), .i_ext_clock_in_c(pins[2]),
    .i_ext_clock_in_d(pins[3]), .i_chan(chan), .i_buffer_enable(buf_en), .i_phase_count_enable(penab),
    .i_phase_step(pstep), .i_phase_down(pdir), .o_counter(cnt), .o_flag_set(flags));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers, result watcher, timeout
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b = 2'b11);
    cpu_bus_model_i.access(a, d, b, 1'b1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] v, input logic [15:0] m = 16'hffff,
                     input logic [15:0] t = 16'h0);
    q.push_back('{v, m, t});
    cpu_bus_model_i.access(a, 16'h0, 2'b11, 1'b0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_init;
    for (int n = 0; n < 5; n++) rdc(`CCR_BASE + 8'(2 * n), 16'h0080, 16'h00ff);
    for (int n = 0; n < 4; n++) rdc(`BRA_BASE + 8'(2 * n), 16'hffff);
  endtask
  task automatic finish_test;
    $display("Checks run: %0d, mismatches: %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) rd_seen <= bus.rd && ce;
  always @(negedge clk) begin
    if (rd_seen) begin
      e = q.pop_front();
      tests_run++;
      if ((((rdata & e.m) - e.v + e.t) <= 2 * e.t) !== 1'b1) begin
        fail_count++;
        $display("Error at %0t: read %h, expected %h", $time, rdata, e.v);
      end
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {rst_b, standby, penab, pstep, pdir, pins, buf_en} = '0;
    ce = 1'b1;
    chan = '0;
    rnd = 16'h0042;
    fail_count = 0;
    tests_run = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    #1 rst_b = 1'b1;
    tick(4);
    chk_init();
    rdc(8'h80, 16'h0);
    for (int n = 0; n < 5; n++) begin
      rnd = lfsr(rnd);
      wr(`CCR_BASE + 8'(2 * n), rnd, 2'b01);
      rdc(`CCR_BASE + 8'(2 * n), {8'h0, rnd[7:0] | 8'h80}, 16'h00ff);
    end
    for (int n = 0; n < 4; n++) begin
      rnd = lfsr(rnd);
      wr(`BRA_BASE + 8'(2 * n), rnd);
      wr(`BRA_BASE + 8'(2 * n), ~rnd, n[0] ? 2'b10 : 2'b01);
      rdc(`BRA_BASE + 8'(2 * n), n[0] ? {~rnd[15:8], rnd[7:0]} : {rnd[15:8], ~rnd[7:0]});
    end
    standby = 1'b1;
    tick(1);
    standby = 1'b0;
    chk_init();
    rnd = lfsr(rnd);
    wr(`CCR_BASE + 8'h08, 16'h0004, 2'b01);
    wr(`CNT_BASE + 8'h08, rnd);
    wr(`GRA_BASE + 8'h08, ~rnd);
    buf_en = 4'b0100;
    chan[4] = '{cap_mode_a: 1'b1, cap_mode_b: 1'b1, cap_evt_a: 1'b1, cap_evt_b: 1'b1, sync_enroll: 1'b0};
    tick(1);
    chan[4].cap_evt_a = 1'b0;
    chan[4].cap_evt_b = 1'b0;
    rdc(`GRA_BASE + 8'h08, rnd);
    rdc(`BRA_BASE + 8'h02, ~rnd);
    rdc(`GRB_BASE + 8'h08, rnd);
    rdc(`BRB_BASE + 8'h02, 16'hffff);
    wr(`CCR_BASE + 8'h06, 16'h0020, 2'b01);
    wr(`GRA_BASE + 8'h06, 16'h0010);
    wr(`BRA_BASE, 16'h0020);
    buf_en = 4'b0101;
    wr(`CNT_BASE + 8'h06, 16'h0);
    tick(60);
    rdc(`GRA_BASE + 8'h06, 16'h0020);
    rdc(`CNT_BASE + 8'h06, 16'h0010, 16'hffff, 16'h0010);
    wr(`GRA_BASE, 16'h0008);
    wr(`GRB_BASE, 16'h000c);
    for (int s = 0; s < 4; s++) begin
      wr(`CCR_BASE, 16'(s << 5), 2'b01);
      wr(`CNT_BASE, 16'h0);
      tick(28);
      rdc(`CNT_BASE, s == 1 ? 16'h4 : s == 2 ? 16'h6 : 16'h1e, 16'hffff, s == 1 ? 16'h4 : s == 2 ? 16'h6 : 16'h2);
    end
    wr(`CCR_BASE, 16'h0020, 2'b01);
    chan[0].cap_mode_a = 1'b1;
    wr(`CNT_BASE, 16'h0);
    tick(20);
    chan[0].cap_evt_a = 1'b1;
    tick(1);
    chan[0].cap_evt_a = 1'b0;
    rdc(`CNT_BASE, 16'h2, 16'hffff, 16'h2);
    chan[0].sync_enroll = 1'b1;
    chan[3].sync_enroll = 1'b1;
    wr(`CCR_BASE, 16'h0060, 2'b01);
    wr(`CNT_BASE + 8'h06, 16'h0);
    tick(40);
    rdc(`CNT_BASE, 16'h0008, 16'hffff, 16'h0);
    for (int d = 0; d < 4; d++) begin
      wr(`CCR_BASE + 8'h02, 16'(d), 2'b01);
      wr(`CNT_BASE + 8'h02, 16'h0);
      tick(62);
      rdc(`CNT_BASE + 8'h02, 16'(64 >> d), 16'hffff, 16'h1);
    end
    chan[4] = '0;
    for (int k = 0; k < 4; k++) begin
      wr(`CCR_BASE + 8'h08, 16'((k << 3) | (4 + k)), 2'b01);
      wr(`CNT_BASE + 8'h08, 16'h0);
      for (int p = 0; p < 4; p++) begin
        pins = 4'(4'hf << p);
        tick(6);
        pins = 4'h0;
        tick(6);
      end
      rdc(`CNT_BASE + 8'h08, k >= 2 ? 16'(2 * (k + 1)) : 16'(k + 1));
    end
    penab = 1'b1;
    wr(`CCR_BASE + 8'h04, 16'h001c, 2'b01);
    wr(`CNT_BASE + 8'h04, 16'h0005);
    pins = 4'h1;
    tick(6);
    pins = 4'h0;
    pdir = 1'b1;
    pstep = 1'b1;
    tick(1);
    pstep = 1'b0;
    tick(6);
    rdc(`CNT_BASE + 8'h04, 16'h0004);
    ce = 1'b0;
    tick(5);
    ce = 1'b1;
    tick(4);
    finish_test();
  end
endmodule
